// File: pkg/rdsc_pkg.sv
// Constants for the reference divider, status and serial control block.
// Assumes one 100 MHz system clock and index addressed 8-bit registers.
package rdsc_pkg;
  // Register index and data widths.
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  // Register indices.
  localparam logic [6:0] REG_STATUS = 7'h00;
  localparam logic [6:0] REG_STAT_SEL = 7'h01;
  localparam logic [6:0] REG_IRQ_STAT = 7'h02;
  localparam logic [6:0] REG_IRQ_MASK = 7'h03;
  localparam logic [6:0] REG_RATIO = 7'h06;
  localparam logic [6:0] REG_CTRL = 7'h07;
  localparam logic [6:0] REG_REFBUF = 7'h0b;
  localparam logic [6:0] REG_LOCK = 7'h0c;
  // Flag bit positions, shared by status, select, event and mask.
  localparam int FLAG_UNLOCK = 0;
  localparam int FLAG_LOCK = 1;
  localparam int FLAG_CLAMP_HI = 2;
  localparam int FLAG_CLAMP_LO = 3;
  // Control fields.
  localparam int CTRL_INT_MODE = 0;
  localparam int CTRL_SOFT_MUTE = 1;
  localparam int REFBUF_FILT_LSB = 0;
  localparam int REFBUF_BOOST = 2;
  // Reset values.
  localparam logic [4:0] RATIO_RST = 5'h01;
  localparam logic [3:0] STAT_SEL_RST = 4'h0;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [2:0] REFBUF_RST = 3'h0;
  localparam logic [1:0] LOCK_CT_RST = 2'h0;
  // Successive in-window counts before lock, per count code.
  localparam logic [11:0] LOCK_COUNT_1 = 12'h020;
  localparam logic [11:0] LOCK_COUNT_2 = 12'h100;
  localparam logic [11:0] LOCK_COUNT_3 = 12'h800;
  // Serial frame: seven address bits, a read bit, eight data bits.
  localparam logic [4:0] SPI_HDR_LAST = 5'h07;
  localparam logic [4:0] SPI_FRAME_LAST = 5'h0f;
  localparam logic [4:0] SPI_FRAME_END = 5'h10;
endpackage : rdsc_pkg

// File: rtl/rdsc_ref_div.sv
// Integer reference divider producing the phase detector clock.
// Assumes the reference is sampled by a faster system clock.
`timescale 1ns/1ps
module rdsc_ref_div #(
  parameter int W = 5
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic ref_i,
  input wire logic [W-1:0] ratio_i,
  output logic div_o
);
  logic ref_q; // Previous reference level.
  logic [W-1:0] cnt; // Reference edges seen in this group.
  logic [W-1:0] next_cnt;
  logic rise;

  ////////////////////////////////////////////////////////////////////
  // Edge detect and group counter.
  assign rise = ref_i & ~ref_q;

  // A ratio of one keeps the counter at zero, so the output follows the
  // reference one cycle late.
  always_comb begin
    next_cnt = cnt;
    if (rise) begin
      if (ratio_i <= W'(1) || cnt + W'(1) >= ratio_i) begin
        next_cnt = '0;
      end else begin
        next_cnt = cnt + W'(1);
      end
    end
  end

  // Counter and edge history.
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      ref_q <= 1'b0;
      cnt <= '0;
    end else begin
      ref_q <= ref_i;
      cnt <= next_cnt;
    end
  end

  // Only the last reference pulse of each group passes.
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      div_o <= 1'b0;
    end else begin
      div_o <= ref_i & (next_cnt == '0);
    end
  end
endmodule : rdsc_ref_div

// File: rtl/rdsc_spi_slave.sv
// Serial control port: frames bursts, shifts bits, reads and writes.
// Assumes serial pins are synchronous and each serial clock phase
// lasts at least two system clocks.
`timescale 1ns/1ps
module rdsc_spi_slave (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_n_o,
  output logic [6:0] addr_o,
  output logic wr_o,
  output logic [7:0] wdata_o,
  input wire logic [7:0] rdata_i
);
  logic sclk_q; // Previous serial clock level.
  logic [6:0] sr; // Incoming bits.
  logic [4:0] bcnt; // Bits taken in this burst.
  logic is_rd; // Burst is a read.
  logic load; // Read data load pending.
  logic [7:0] tx; // Outgoing bits.
  logic s_rise;
  logic s_fall;

  assign s_rise = sclk_i & ~sclk_q;
  assign s_fall = ~sclk_i & sclk_q;
  assign sdo_o = tx[7];

  ////////////////////////////////////////////////////////////////////
  // Receive side. Chip select high abandons any partial burst.
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      sclk_q <= 1'b0;
      sr <= '0;
      bcnt <= '0;
      is_rd <= 1'b0;
      addr_o <= '0;
      wr_o <= 1'b0;
      wdata_o <= '0;
      load <= 1'b0;
    end else begin
      sclk_q <= sclk_i;
      wr_o <= 1'b0;
      load <= 1'b0;
      if (cs_n_i) begin
        bcnt <= '0;
        is_rd <= 1'b0;
      end else if (s_rise && bcnt != rdsc_pkg::SPI_FRAME_END) begin
        sr <= {sr[5:0], sdi_i};
        bcnt <= bcnt + 5'h01;
        if (bcnt == rdsc_pkg::SPI_HDR_LAST) begin
          addr_o <= sr;
          is_rd <= sdi_i;
          load <= sdi_i;
        end
        if (bcnt == rdsc_pkg::SPI_FRAME_LAST && !is_rd) begin
          wr_o <= 1'b1;
          wdata_o <= {sr, sdi_i};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Transmit side: drive only in the data phase of a read.
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      tx <= '0;
      sdo_oe_n_o <= 1'b1;
    end else if (cs_n_i) begin
      sdo_oe_n_o <= 1'b1;
    end else if (load) begin
      tx <= rdata_i;
      sdo_oe_n_o <= 1'b0;
    end else if (s_fall && !sdo_oe_n_o && bcnt != rdsc_pkg::SPI_HDR_LAST + 5'h01) begin
      // The fall between the read bit and the first data rise keeps the
      // top bit, otherwise the host would see bit six at its first rise.
      tx <= {tx[6:0], 1'b0};
    end
  end
endmodule : rdsc_spi_slave

// File: rtl/rdsc_top.sv
// Reference path and control pin logic of the synthesizer.
// Assumes all pins are synchronous to clk_sys_i; analog comparators
// supply the window and clamp levels.
//
// How it works
// - Status pin ORs selected flags.
// - Chip select low frames each burst.
// - Serial input sampled on clock rising edge.
// - Serial output driven only during reads.
// - Mute silences outputs, bias stays on.
// - Five-bit ratio, values one to thirtyone.
// - Modulator can be disabled for integer mode.
// - Unlock immediate on window exit, clears lock.
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module rdsc_top (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // Plain register port.
  input wire logic [6:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Serial control port.
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_n_o,
  // Reference path.
  input wire logic ref_i,
  output logic pfd_ref_o,
  output logic [1:0] ref_filter_sel_o,
  output logic ref_gain_boost_o,
  // Loop monitors from the analog side and the modulator enable.
  input wire logic phase_in_window_i,
  input wire logic clamp_high_i,
  input wire logic clamp_low_i,
  output logic dsm_enable_o,
  // Output buffer control.
  input wire logic mute_n_i,
  output logic rf_out_en_o,
  output logic rf_bias_en_o,
  // Status and interrupt.
  output logic stat_o,
  output logic irq_o
);
  ////////////////////////////////////////////////////////////////////
  // Registers.
  logic [4:0] ratio; // Reference divide ratio.
  logic [3:0] stat_sel; // Flags routed to the status pin.
  logic [3:0] irq_stat; // Sticky event bits.
  logic [3:0] irq_mask; // Event enables.
  logic [1:0] ctrl; // Integer mode and soft mute.
  logic [2:0] refbuf; // Filter code and gain boost.
  logic [1:0] lock_ct; // Lock count code, zero disables.

  // Merged write request from both ports.
  logic wr_en;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;

  // Serial port side.
  logic spi_wr;
  logic [6:0] spi_addr;
  logic [7:0] spi_wdata;
  logic [7:0] spi_rdata;

  // Flags and their history.
  logic [3:0] flags;
  logic [3:0] flags_q;
  logic lock_flag;
  logic unlock_flag;
  logic clamp_high_flag;
  logic clamp_low_flag;
  logic lk_en;
  logic [11:0] lk_cnt; // Successive in-window phase detector cycles.
  logic [11:0] lk_target;
  logic pfd_q; // Previous divider output.
  logic pfd_tick;

  ////////////////////////////////////////////////////////////////////
  // Serial port instance.
  rdsc_spi_slave u_spi (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .cs_n_i(cs_n_i),
    .sclk_i(sclk_i),
    .sdi_i(sdi_i),
    .sdo_o(sdo_o),
    .sdo_oe_n_o(sdo_oe_n_o),
    .addr_o(spi_addr),
    .wr_o(spi_wr),
    .wdata_o(spi_wdata),
    .rdata_i(spi_rdata)
  );

  // The plain port wins a same-cycle collision; the serial write is
  // lost then, which is rare since serial writes are slow.
  assign wr_en = reg_wr_i | spi_wr;
  assign wr_addr = reg_wr_i ? reg_addr_i : spi_addr;
  assign wr_data = reg_wr_i ? reg_wdata_i : spi_wdata;

  ////////////////////////////////////////////////////////////////////
  // Read multiplexer shared by both ports; unmapped reads give zero.
  function automatic logic [7:0] rd_mux(input logic [6:0] a);
    logic [7:0] d;
    d = 8'h00;
    case (a)
      rdsc_pkg::REG_STATUS: d = {4'h0, flags};
      rdsc_pkg::REG_STAT_SEL: d = {4'h0, stat_sel};
      rdsc_pkg::REG_IRQ_STAT: d = {4'h0, irq_stat};
      rdsc_pkg::REG_IRQ_MASK: d = {4'h0, irq_mask};
      rdsc_pkg::REG_RATIO: d = {3'h0, ratio};
      rdsc_pkg::REG_CTRL: d = {6'h00, ctrl};
      rdsc_pkg::REG_REFBUF: d = {5'h00, refbuf};
      rdsc_pkg::REG_LOCK: d = {6'h00, lock_ct};
      default: d = 8'h00;
    endcase
    return d;
  endfunction : rd_mux

  // A process rather than an assign, so that a change of any register
  // behind the multiplexer reaches the serial side, not only a new index.
  always_comb begin
    spi_rdata = rd_mux(spi_addr);
  end

  // Plain port read data stand in the cycle after the strobe only.
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_mux(reg_addr_i);
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Configuration writes.
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      ratio <= rdsc_pkg::RATIO_RST;
      stat_sel <= rdsc_pkg::STAT_SEL_RST;
      irq_mask <= 4'h0;
      ctrl <= rdsc_pkg::CTRL_RST;
      refbuf <= rdsc_pkg::REFBUF_RST;
      lock_ct <= rdsc_pkg::LOCK_CT_RST;
    end else if (wr_en) begin
      case (wr_addr)
        rdsc_pkg::REG_RATIO: begin
          // A zero ratio is not a legal divide and is ignored.
          if (wr_data[4:0] != 5'h00) begin
            ratio <= wr_data[4:0];
          end
        end
        rdsc_pkg::REG_STAT_SEL: stat_sel <= wr_data[3:0];
        rdsc_pkg::REG_IRQ_MASK: irq_mask <= wr_data[3:0];
        rdsc_pkg::REG_CTRL: ctrl <= wr_data[1:0];
        // The filter code is stored as written; code two is software's
        // mistake to avoid.
        rdsc_pkg::REG_REFBUF: refbuf <= wr_data[2:0];
        rdsc_pkg::REG_LOCK: lock_ct <= wr_data[1:0];
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Reference divider toward the phase detector.
  rdsc_ref_div #(
    .W(5)
  ) u_div (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .ref_i(ref_i),
    .ratio_i(ratio),
    .div_o(pfd_ref_o)
  );

  // One tick per phase detector cycle.
  assign pfd_tick = pfd_ref_o & ~pfd_q;

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      pfd_q <= 1'b0;
    end else begin
      pfd_q <= pfd_ref_o;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Lock indicator.
  assign lk_en = (lock_ct != 2'h0);

  always_comb begin
    case (lock_ct)
      2'h1: lk_target = rdsc_pkg::LOCK_COUNT_1;
      2'h2: lk_target = rdsc_pkg::LOCK_COUNT_2;
      2'h3: lk_target = rdsc_pkg::LOCK_COUNT_3;
      default: lk_target = 12'h000;
    endcase
  end

  // Unlock follows the window comparator with no delay.
  assign unlock_flag = lk_en & ~phase_in_window_i;

  // Lock needs the programmed run of in-window cycles and drops at
  // once when the phase leaves the window.
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      lk_cnt <= 12'h000;
      lock_flag <= 1'b0;
    end else if (!lk_en || !phase_in_window_i) begin
      lk_cnt <= 12'h000;
      lock_flag <= 1'b0;
    end else if (pfd_tick && !lock_flag) begin
      lk_cnt <= lk_cnt + 12'h001;
      if (lk_cnt + 12'h001 >= lk_target) begin
        lock_flag <= 1'b1;
      end
    end
  end

  assign clamp_high_flag = clamp_high_i;
  assign clamp_low_flag = clamp_low_i;

  always_comb begin
    flags = 4'h0;
    flags[rdsc_pkg::FLAG_UNLOCK] = unlock_flag;
    flags[rdsc_pkg::FLAG_LOCK] = lock_flag;
    flags[rdsc_pkg::FLAG_CLAMP_HI] = clamp_high_flag;
    flags[rdsc_pkg::FLAG_CLAMP_LO] = clamp_low_flag;
  end

  ////////////////////////////////////////////////////////////////////
  // Status pin, one cycle behind the flags.
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      stat_o <= 1'b0;
    end else begin
      stat_o <= |(flags & stat_sel);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Events are rising flags. A new event beats a same-cycle clear.
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      flags_q <= 4'h0;
      irq_stat <= 4'h0;
    end else begin
      flags_q <= flags;
      if (wr_en && wr_addr == rdsc_pkg::REG_IRQ_STAT) begin
        irq_stat <= (irq_stat & ~wr_data[3:0]) | (flags & ~flags_q);
      end else begin
        irq_stat <= irq_stat | (flags & ~flags_q);
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Loop and buffer controls.
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      dsm_enable_o <= 1'b1;
      ref_filter_sel_o <= 2'h0;
      ref_gain_boost_o <= 1'b0;
      rf_out_en_o <= 1'b0;
      rf_bias_en_o <= 1'b0;
    end else begin
      dsm_enable_o <= ~ctrl[rdsc_pkg::CTRL_INT_MODE];
      ref_filter_sel_o <= refbuf[rdsc_pkg::REFBUF_FILT_LSB +: 2];
      ref_gain_boost_o <= refbuf[rdsc_pkg::REFBUF_BOOST];
      // Bias stays up through a mute so the output returns quickly.
      rf_bias_en_o <= 1'b1;
      rf_out_en_o <= mute_n_i & ~ctrl[rdsc_pkg::CTRL_SOFT_MUTE];
    end
  end
endmodule : rdsc_top

// File: verification/rdsc_top_sva.sv
// Checker for the ports of the reference path and control pin block.
// Assumes one system clock and a synchronous active-low reset.
`timescale 1ns/1ps
module rdsc_top_sva (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic cs_n_i,
  input wire logic sdo_oe_n_o,
  input wire logic [1:0] ref_filter_sel_o,
  input wire logic ref_gain_boost_o,
  input wire logic dsm_enable_o,
  input wire logic mute_n_i,
  input wire logic rf_out_en_o,
  input wire logic rf_bias_en_o
);
  ////////////////////////////////////////
  // All checks share one clock, so default clocking keeps them short.
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  // An unmapped index must read back as zero.
  property p_unmapped; reg_rd_i && reg_addr_i == 7'h7f |=> reg_rdata_o == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  // The ratio field is five bits, so the upper bits read zero.
  property p_ratio_w; reg_rd_i && reg_addr_i == rdsc_pkg::REG_RATIO |=> reg_rdata_o[7:5] == 3'h0;
  endproperty
  a_ratio_w: assert property (p_ratio_w) else $error("ratio upper bits set");
  // The output stays released while no burst is in progress.
  property p_oe_idle; cs_n_i [*3] |-> sdo_oe_n_o; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("sdo driven outside burst");
  // Driving may only start inside a framed burst.
  property p_oe_start; $fell(sdo_oe_n_o) |-> !cs_n_i; endproperty
  a_oe_start: assert property (p_oe_start) else $error("sdo driven without select");
  // Mute silences the RF outputs on the next edge.
  property p_mute; !mute_n_i |=> !rf_out_en_o; endproperty
  a_mute: assert property (p_mute) else $error("rf output not muted");
  // Bias stays on whatever the mute does, so release is quick.
  property p_bias; $past(nrst_i) |=> rf_bias_en_o; endproperty
  a_bias: assert property (p_bias) else $error("bias dropped");
  // Integer mode written to control turns the modulator off.
  property p_dsm;
    reg_wr_i && reg_addr_i == rdsc_pkg::REG_CTRL |-> ##2 dsm_enable_o == !$past(reg_wdata_i[0], 2);
  endproperty
  a_dsm: assert property (p_dsm) else $error("modulator enable wrong");
  // Filter and boost follow their register fields.
  property p_refbuf;
    reg_wr_i && reg_addr_i == rdsc_pkg::REG_REFBUF |->
      ##2 {ref_gain_boost_o, ref_filter_sel_o} == $past(reg_wdata_i[2:0], 2);
  endproperty
  a_refbuf: assert property (p_refbuf) else $error("buffer settings wrong");
endmodule : rdsc_top_sva
bind rdsc_top rdsc_top_sva u_sva (.clk_sys_i, .nrst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
  .reg_rd_i, .reg_rdata_o, .cs_n_i, .sdo_oe_n_o, .ref_filter_sel_o, .ref_gain_boost_o,
  .dsm_enable_o, .mute_n_i, .rf_out_en_o, .rf_bias_en_o);

// File: verification/rdsc_host_model.sv
// Host controller model driving the serial control port.
// Assumes serial clock phases of four system clocks low and eight high are slow enough.
`timescale 1ns/1ps
module rdsc_host_model (
  input wire logic clk_sys_i,
  input wire logic sdo_o,
  input wire logic sdo_oe_n_o,
  output logic cs_n_o,
  output logic sclk_o,
  output logic sdi_o
);
  ////////////////////////////////////////
  logic sdo_last; // Last bit seen while the device drove.
  logic sdo_line; // Level on the wire as the host sees it.
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    sdi_o = 1'b0;
  end
  // No pull is fitted, so a released line shows the inverse of the last bit.
  always @(posedge clk_sys_i) begin
    if (!sdo_oe_n_o) begin
      sdo_last <= sdo_o;
    end
  end
  assign sdo_line = sdo_oe_n_o ? !sdo_last : sdo_o;
  // One burst, MSB first; fewer than sixteen bits aborts it.
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] d,
                      input int nb, output logic [7:0] q);
    logic [15:0] f;
    f = {a, rd, d};
    q = 8'h00;
    @(posedge clk_sys_i);
    cs_n_o <= 1'b0;
    for (int i = 0; i < nb; i++) begin
      repeat (4) @(posedge clk_sys_i);
      sclk_o <= 1'b0;
      sdi_o <= f[15-i];
      repeat (4) @(posedge clk_sys_i);
      sclk_o <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      if (i > 7) begin
        q = {q[6:0], sdo_line};
      end
    end
    sclk_o <= 1'b0;
    sdi_o <= !sdi_o;
    repeat (2) @(posedge clk_sys_i);
    cs_n_o <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
  endtask : xfer
endmodule : rdsc_host_model

// File: verification/ref_divider_status_ctrl_test.sv
// Self-checking bench for the reference path and control pin block.
// Assumes the host model on the serial port and the checker bound in.
`timescale 1ns/1ps
module ref_divider_status_ctrl_test;
  logic clk_sys_i, nrst_i, reg_wr_i, reg_rd_i, ref_i, win, chi, clo, mute_n;
  logic [6:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o, q;
  logic cs_n, sclk, sdi, sdo, sdo_oe_n, pfd, boost, dsm, rfo, bias, stat, irq;
  logic [1:0] filt;
  int num_errors, check_count, n, r;
  ////////////////////////////////////////
  rdsc_top dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .cs_n_i(cs_n), .sclk_i(sclk), .sdi_i(sdi), .sdo_o(sdo),
    .sdo_oe_n_o(sdo_oe_n), .ref_i(ref_i), .pfd_ref_o(pfd), .ref_filter_sel_o(filt),
    .ref_gain_boost_o(boost), .phase_in_window_i(win), .clamp_high_i(chi),
    .clamp_low_i(clo), .dsm_enable_o(dsm), .mute_n_i(mute_n), .rf_out_en_o(rfo),
    .rf_bias_en_o(bias), .stat_o(stat), .irq_o(irq));
  rdsc_host_model host (.clk_sys_i(clk_sys_i), .sdo_o(sdo), .sdo_oe_n_o(sdo_oe_n),
    .cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi));
  // Clock of 10 ns and a free-running reference of eight clocks a period.
  initial begin
    clk_sys_i = 1'b0;
    ref_i = 1'b0;
    forever #5 clk_sys_i = !clk_sys_i;
  end
  always begin
    repeat (4) @(posedge clk_sys_i);
    ref_i <= !ref_i;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys_i);
    #1;
  endtask : cyc
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  // Read data stands only in the cycle after the strobe.
  task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(reg_rdata_o, exp);
  endtask : rdc
  // Counts reference rises between two divided-clock rises; a hang gives a short count.
  task automatic meas(output int cnt);
    logic pp, pr;
    int st;
    cnt = 0;
    st = 0;
    pp = pfd;
    pr = ref_i;
    for (int t = 0; t < 1200 && st < 2; t++) begin
      cyc(1);
      if (st == 1 && ref_i && !pr) cnt++;
      if (pfd && !pp) st++;
      pp = pfd;
      pr = ref_i;
    end
  endtask : meas
  task automatic results;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results
  initial begin
    #400000;
    num_errors++;
    results();
  end
  initial begin
    {nrst_i, reg_wr_i, reg_rd_i, win, chi, clo} = 6'h00;
    {reg_addr_i, reg_wdata_i} = 15'h0000;
    mute_n = 1'b1;
    void'($urandom(8879));
    repeat (20) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    cyc(2);
    chk(dsm, 1'b1);
    rdc(rdsc_pkg::REG_RATIO, 8'h01);
    wr(7'h7f, 8'hff);
    rdc(7'h7f, 8'h00);
    // Ratio corners first, then random; a zero write must not stick.
    for (int i = 0; i < 6; i++) begin
      r = (i == 0) ? 1 : (i == 1) ? 31 : 1 + $urandom % 31;
      wr(rdsc_pkg::REG_RATIO, r[7:0]);
      wr(rdsc_pkg::REG_RATIO, 8'h00);
      rdc(rdsc_pkg::REG_RATIO, r[7:0]);
      meas(n);
      meas(n);
      chk(n[7:0], r[7:0]);
    end
    // Serial write, aborted write and serial read.
    host.xfer(1'b0, rdsc_pkg::REG_REFBUF, 8'h05, 16, q);
    rdc(rdsc_pkg::REG_REFBUF, 8'h05);
    host.xfer(1'b0, rdsc_pkg::REG_REFBUF, 8'h02, 10, q);
    rdc(rdsc_pkg::REG_REFBUF, 8'h05);
    host.xfer(1'b1, rdsc_pkg::REG_RATIO, 8'h00, 16, q);
    chk(q, r[7:0]);
    // Random control, mute and buffer settings.
    for (int i = 0; i < 8; i++) begin
      r = $urandom;
      @(posedge clk_sys_i);
      mute_n <= r[3];
      wr(rdsc_pkg::REG_CTRL, {6'h00, r[1:0]});
      wr(rdsc_pkg::REG_REFBUF, {5'h00, r[6:4]});
      cyc(3);
      chk(dsm, !r[0]);
      chk(rfo, r[3] & !r[1]);
      chk(bias, 1'b1);
      chk(filt, r[5:4]);
      chk(boost, r[6]);
    end
    wr(rdsc_pkg::REG_CTRL, 8'h00);
    mute_n <= 1'b1;
    // Each clamp flag reaches the status pin when it is selected.
    for (int i = 2; i < 4; i++) begin
      wr(rdsc_pkg::REG_STAT_SEL, 8'h01 << i);
      cyc(3);
      chk(stat, 1'b0);
      chi <= (i == 2);
      clo <= (i == 3);
      cyc(4);
      chk(stat, 1'b1);
      rdc(rdsc_pkg::REG_STATUS, 8'h01 << i);
      chi <= 1'b0;
      clo <= 1'b0;
    end
    // Interrupt raised, masked, unmasked and cleared.
    wr(rdsc_pkg::REG_IRQ_STAT, 8'h0f);
    rdc(rdsc_pkg::REG_IRQ_STAT, 8'h00);
    clo <= 1'b1;
    cyc(2);
    clo <= 1'b0;
    cyc(3);
    rdc(rdsc_pkg::REG_IRQ_STAT, 8'h08);
    chk(irq, 1'b0);
    wr(rdsc_pkg::REG_IRQ_MASK, 8'h08);
    cyc(3);
    chk(irq, 1'b1);
    wr(rdsc_pkg::REG_IRQ_STAT, 8'h08);
    cyc(3);
    chk(irq, 1'b0);
    // Lock after 32 counts, then unlock at once on leaving the window.
    wr(rdsc_pkg::REG_RATIO, 8'h01);
    win <= 1'b1;
    wr(rdsc_pkg::REG_LOCK, 8'h01);
    cyc(400);
    rdc(rdsc_pkg::REG_STATUS, 8'h02);
    wr(rdsc_pkg::REG_STAT_SEL, 8'h01);
    win <= 1'b0;
    cyc(12);
    chk(stat, 1'b1);
    rdc(rdsc_pkg::REG_STATUS, 8'h01);
    win <= 1'b1;
    cyc(12);
    rdc(rdsc_pkg::REG_STATUS, 8'h00);
    // The middle count code needs 256 ticks, eight clocks each, before lock.
    wr(rdsc_pkg::REG_LOCK, 8'h02);
    cyc(1800);
    rdc(rdsc_pkg::REG_STATUS, 8'h00);
    cyc(300);
    rdc(rdsc_pkg::REG_STATUS, 8'h02);
    results();
  end
endmodule : ref_divider_status_ctrl_test
